/* bench/tb.sv */
`timescale 1ns/1ps
module tb
    import amp_regs_pkg::*;
;
    localparam logic [7:0] A_OUT = {2'h0, IDX_OUTPUT_STAGE, 2'h0};
    localparam logic [7:0] A_FLT = {2'h0, IDX_FAULT, 2'h0};
    localparam logic [7:0] A_IST = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_IMK = {2'h0, IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] A_SPD = {2'h0, IDX_SPEED, 2'h0};
    localparam logic [4:0] MULT_EXP [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
    localparam logic [6:0] PCT_EXP [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    logic clock_invalid = 1'b0;
    // bit order matches the latched flags in the fault register
    logic [2:0] fault_pin = 3'h0;
    logic amp_shutdown_n = 1'b1;
    logic parallel_bridge_select;
    logic mono_source_channel;
    logic [1:0] analog_gain_code;
    logic [4:0] switch_rate_mult;
    logic [6:0] overcurrent_trip_pct;
    logic amp_enable;
    logic irq;
    int error_cnt = 0;
    int comparisons = 0;

    amp_mode_and_fault_registers DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_invalid,
        .overcurrent_detect(fault_pin[2]), .output_offset_detect(fault_pin[1]),
        .overtemp_detect(fault_pin[0]), .amp_shutdown_n, .parallel_bridge_select,
        .mono_source_channel, .analog_gain_code, .switch_rate_mult, .overcurrent_trip_pct,
        .amp_enable, .irq
    );

    always #25 aclk = ~aclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        check({31'h0, s_axi_bvalid}, 32'h1);
        check(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        check({31'h0, s_axi_rvalid}, 32'h1);
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic close_out();
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(8);
        rd_chk(A_OUT, 32'h51, RESP_OKAY);
        rd_chk(A_FLT, 32'h0, RESP_OKAY);
        rd_chk(A_IMK, 32'h0, RESP_OKAY);
        rd_chk(A_SPD, 32'h0, RESP_OKAY);
        check({27'h0, switch_rate_mult}, 32'h10);
        check({25'h0, overcurrent_trip_pct}, 32'h64);
        check({26'h0, amp_enable, irq, parallel_bridge_select, mono_source_channel, analog_gain_code}, 32'h20);
        for (int c = 0; c < 8; c++) begin
            wr(A_OUT, {1'b0, 3'(c), 4'h1}, RESP_OKAY);
            cyc(2);
            check({27'h0, switch_rate_mult}, {27'h0, MULT_EXP[c]});
            rd_chk(A_OUT, {24'h0, 1'b0, 3'(c), 4'h1}, RESP_OKAY);
        end
        wr(A_SPD, 8'h01, RESP_OKAY);
        cyc(3);
        check({27'h0, switch_rate_mult}, {27'h0, MULT_EXP[7] >> 1});
        wr(A_OUT, 8'h01, RESP_OKAY);
        cyc(3);
        check({27'h0, switch_rate_mult}, {27'h0, MULT_EXP[0] >> 1});
        wr(A_SPD, 8'h00, RESP_OKAY);
        cyc(3);
        check({27'h0, switch_rate_mult}, {27'h0, MULT_EXP[0]});
        for (int g = 0; g < 3; g++) begin
            wr(A_OUT, {1'b1, 3'h5, 2'(g), 2'h3}, RESP_OKAY);
            cyc(2);
            check({30'h0, analog_gain_code}, 32'(g));
            check({30'h0, parallel_bridge_select, mono_source_channel}, 32'h3);
        end
        // gain code 11 must leave the field at its last legal value
        wr(A_OUT, 8'h5d, RESP_OKAY);
        cyc(2);
        rd_chk(A_OUT, 32'h59, RESP_OKAY);
        check({30'h0, analog_gain_code}, 32'h2);
        check({30'h0, parallel_bridge_select, mono_source_channel}, 32'h0);
        wr(A_OUT, 8'h99, RESP_OKAY);
        cyc(2);
        check({30'h0, parallel_bridge_select, mono_source_channel}, 32'h2);
        s_axi_wstrb <= 4'he;
        wr(A_OUT, 8'h01, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd_chk(A_OUT, 32'h99, RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            wr(A_FLT, {2'h0, 2'(s), 4'hf}, RESP_OKAY);
            cyc(2);
            rd_chk(A_FLT, {26'h0, 2'(s), 4'h0}, RESP_OKAY);
            check({25'h0, overcurrent_trip_pct}, {25'h0, PCT_EXP[s]});
        end
        rd_chk(8'h3c, 32'h0, RESP_SLVERR);
        wr(8'h3c, 8'hff, RESP_SLVERR);
        rd_chk(8'h19, 32'h0, RESP_SLVERR);
        clock_invalid <= 1'b1;
        cyc(6);
        rd_chk(A_FLT, 32'h38, RESP_OKAY);
        check({30'h0, amp_enable, irq}, 32'h0);
        clock_invalid <= 1'b0;
        cyc(6);
        rd_chk(A_FLT, 32'h30, RESP_OKAY);
        check({31'h0, amp_enable}, 32'h1);
        rd_chk(A_IST, 32'h8, RESP_OKAY);
        wr(A_IST, 8'h0f, RESP_OKAY);
        rd_chk(A_IST, 32'h0, RESP_OKAY);
        for (int b = 0; b < 3; b++) begin
            wr(A_IMK, 8'(1 << b), RESP_OKAY);
            fault_pin[b] <= 1'b1;
            cyc(5);
            fault_pin[b] <= 1'b0;
            cyc(6);
            rd_chk(A_FLT, 32'h30 | (32'h1 << b), RESP_OKAY);
            check({30'h0, amp_enable, irq}, 32'h1);
            amp_shutdown_n <= 1'b0;
            cyc(5);
            amp_shutdown_n <= 1'b1;
            cyc(6);
            rd_chk(A_FLT, 32'h30, RESP_OKAY);
            check({30'h0, amp_enable, irq}, 32'h3);
            wr(A_IST, 8'(1 << b), RESP_OKAY);
            cyc(3);
            check({31'h0, irq}, 32'h0);
        end
        close_out();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // tb

/* verilog/amp_mode_and_fault_registers.sv */
`timescale 1ns/1ps
module amp_mode_and_fault_registers
    import amp_regs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_invalid,
    input wire logic overcurrent_detect,
    input wire logic output_offset_detect,
    input wire logic overtemp_detect,
    input wire logic amp_shutdown_n,
    output logic parallel_bridge_select,
    output logic mono_source_channel,
    output logic [1:0] analog_gain_code,
    output logic [4:0] switch_rate_mult,
    output logic [6:0] overcurrent_trip_pct,
    output logic amp_enable,
    output logic irq
);
    logic [7:0] output_stage_config;
    logic [1:0] overcurrent_trip_scale;
    logic double_speed;
    logic [FLAG_W-1:0] irq_status;
    logic [FLAG_W-1:0] irq_mask;
    logic [FLAG_W-1:0] fault_now;
    logic [FLAG_W-1:0] fault_prev;
    logic [FLAG_W-1:0] fault_rise;
    logic [7:0] fault_config_and_status;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic do_write;
    logic wr_mapped;
    logic [3:0] wr_idx;
    logic rd_mapped;
    logic [3:0] rd_idx;
    logic [7:0] next_rdata;
    logic [2:0] rate_code;

    fault_if flags ();

    fault_monitor u_fault_monitor (
        .aclk(aclk),
        .aresetn(aresetn),
        .clock_invalid(clock_invalid),
        .overcurrent_detect(overcurrent_detect),
        .output_offset_detect(output_offset_detect),
        .overtemp_detect(overtemp_detect),
        .amp_shutdown_n(amp_shutdown_n),
        .flags(flags.monitor)
    );

    assign fault_now = {flags.clock_fault_flag, flags.overcurrent_fault_flag,
                        flags.output_offset_fault_flag, flags.overtemp_fault_flag};
    assign fault_rise = fault_now & ~fault_prev;
    assign fault_config_and_status = {2'h0, overcurrent_trip_scale, fault_now};

    // write channel: address and data taken in either order, response after both
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wr_idx = wr_addr[5:2];
    assign wr_mapped = (wr_addr[1:0] == 2'h0) && (wr_addr[ADDR_W-1:6] == '0)
        && (wr_idx == IDX_OUTPUT_STAGE || wr_idx == IDX_RESERVED_SLOT || wr_idx == IDX_FAULT
            || wr_idx == IDX_IRQ_STATUS || wr_idx == IDX_IRQ_MASK || wr_idx == IDX_SPEED);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wr_data <= 8'h00;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // output stage configuration; the reserved gain code is refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_stage_config <= OUTPUT_STAGE_RESET;
        end else if (do_write && wr_mapped && wr_lane0 && wr_idx == IDX_OUTPUT_STAGE) begin
            output_stage_config[TOPO_BIT] <= wr_data[TOPO_BIT];
            output_stage_config[RATE_MSB:RATE_LSB] <= wr_data[RATE_MSB:RATE_LSB];
            output_stage_config[CHSEL_BIT] <= wr_data[CHSEL_BIT];
            output_stage_config[RSVD_BIT] <= wr_data[RSVD_BIT];
            if (wr_data[GAIN_MSB:GAIN_LSB] != GAIN_RESERVED) begin
                output_stage_config[GAIN_MSB:GAIN_LSB] <= wr_data[GAIN_MSB:GAIN_LSB];
            end
        end
    end

    // only the trip scale of the fault register is writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overcurrent_trip_scale <= TRIP_RESET;
        end else if (do_write && wr_mapped && wr_lane0 && wr_idx == IDX_FAULT) begin
            overcurrent_trip_scale <= wr_data[TRIP_MSB:TRIP_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            double_speed <= DOUBLE_SPEED_RESET;
        end else if (do_write && wr_mapped && wr_lane0 && wr_idx == IDX_SPEED) begin
            double_speed <= wr_data[DOUBLE_SPEED_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= IRQ_RESET;
        end else if (do_write && wr_mapped && wr_lane0 && wr_idx == IDX_IRQ_MASK) begin
            irq_mask <= wr_data[FLAG_W-1:0];
        end
    end

    // sticky events on each fault rising; a new event beats a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_prev <= '0;
            irq_status <= IRQ_RESET;
        end else begin
            fault_prev <= fault_now;
            if (do_write && wr_mapped && wr_lane0 && wr_idx == IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~wr_data[FLAG_W-1:0]) | fault_rise;
            end else begin
                irq_status <= irq_status | fault_rise;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // read channel
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_mapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[ADDR_W-1:6] == '0)
        && (rd_idx == IDX_OUTPUT_STAGE || rd_idx == IDX_RESERVED_SLOT || rd_idx == IDX_FAULT
            || rd_idx == IDX_IRQ_STATUS || rd_idx == IDX_IRQ_MASK || rd_idx == IDX_SPEED);

    always_comb begin
        next_rdata = 8'h00;
        if (rd_mapped) begin
            unique case (rd_idx)
                IDX_OUTPUT_STAGE: next_rdata = output_stage_config;
                IDX_FAULT: next_rdata = fault_config_and_status;
                IDX_IRQ_STATUS: next_rdata = {4'h0, irq_status};
                IDX_IRQ_MASK: next_rdata = {4'h0, irq_mask};
                IDX_SPEED: next_rdata = {7'h00, double_speed};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, next_rdata};
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // drive the output stage from the stored settings
    assign rate_code = output_stage_config[RATE_MSB:RATE_LSB];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            parallel_bridge_select <= 1'b0;
            mono_source_channel <= 1'b0;
            analog_gain_code <= 2'h0;
            switch_rate_mult <= 5'h00;
            overcurrent_trip_pct <= 7'h00;
        end else begin
            parallel_bridge_select <= output_stage_config[TOPO_BIT];
            mono_source_channel <= output_stage_config[CHSEL_BIT];
            analog_gain_code <= output_stage_config[GAIN_MSB:GAIN_LSB];
            switch_rate_mult <= double_speed ? (RATE_MULT[rate_code] >> 1) : RATE_MULT[rate_code];
            overcurrent_trip_pct <= TRIP_PCT[overcurrent_trip_scale];
        end
    end

    // any fault stops the amplifier; clock faults release it on their own
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amp_enable <= 1'b0;
        end else begin
            amp_enable <= flags.shutdown_released & ~(|fault_now);
        end
    end

    sequence stage_write_s;
        do_write && wr_mapped && wr_lane0 && wr_idx == IDX_OUTPUT_STAGE;
    endsequence

    sequence fault_write_s;
        do_write && wr_mapped && wr_lane0 && wr_idx == IDX_FAULT;
    endsequence

    topology_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stage_write_s |-> ##2 parallel_bridge_select == $past(wr_data[TOPO_BIT], 2))
        else $error("topology output did not follow the written bit");

    rate_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !double_speed && rate_code == 3'h5 |=> switch_rate_mult == 5'h10)
        else $error("default rate code did not give sixteen times");

    rate_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
        double_speed && rate_code == 3'h7 |=> switch_rate_mult == 5'h0c)
        else $error("double speed did not halve the switching rate");

    gain_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stage_write_s ##0 (wr_data[GAIN_MSB:GAIN_LSB] == GAIN_RESERVED)
        |=> $stable(output_stage_config[GAIN_MSB:GAIN_LSB]) ##1 analog_gain_code != GAIN_RESERVED)
        else $error("reserved gain code reached the gain field");

    source_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stage_write_s |-> ##2 mono_source_channel == $past(wr_data[CHSEL_BIT], 2))
        else $error("source channel output did not follow the written bit");

    trip_scale_a: assert property (@(posedge aclk) disable iff (!aresetn)
        overcurrent_trip_scale == 2'h2 |=> overcurrent_trip_pct == 7'h32)
        else $error("trip scale code 10 did not give half level");

    clock_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_mapped && rd_idx == IDX_FAULT
        |=> s_axi_rdata[CLKF_BIT] == $past(flags.clock_fault_flag))
        else $error("clock fault bit read back wrong");

    ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_write_s |=> fault_config_and_status[7:6] == 2'h0
            && overcurrent_trip_scale == $past(wr_data[TRIP_MSB:TRIP_LSB]))
        else $error("write disturbed read-only fault bits");

    fault_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags.overcurrent_fault_flag |=> !amp_enable)
        else $error("amplifier ran with a latched overcurrent fault");

    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing one cycle after both channels taken");

    sequence faults_clear_s;
        flags.shutdown_released && fault_now == '0;
    endsequence

    sequence read_taken_s;
        s_axi_arvalid && s_axi_arready;
    endsequence

    rate_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !double_speed && rate_code == 3'h7 |=> switch_rate_mult == 5'h18)
        else $error("rate code 111 did not give twenty-four times");

    rate_low_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
        double_speed && rate_code == 3'h0 |=> switch_rate_mult == 5'h03)
        else $error("double speed did not halve the lowest rate");

    gain_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stage_write_s ##0 (wr_data[GAIN_MSB:GAIN_LSB] != GAIN_RESERVED)
        |-> ##2 analog_gain_code == $past(wr_data[GAIN_MSB:GAIN_LSB], 2))
        else $error("gain output did not follow a legal written code");

    trip_quarter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        overcurrent_trip_scale == 2'h3 |=> overcurrent_trip_pct == 7'h19)
        else $error("trip scale code 11 did not give quarter level");

    clock_resume_a: assert property (@(posedge aclk) disable iff (!aresetn)
        faults_clear_s |=> amp_enable)
        else $error("amplifier did not resume with valid clocks and no fault");

    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        read_taken_s |=> s_axi_rvalid)
        else $error("read data missing one cycle after the address was taken");

    status_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_rise[OCF_BIT] |=> irq_status[OCF_BIT])
        else $error("overcurrent event did not set its status bit");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |(irq_status & irq_mask) |=> irq)
        else $error("interrupt low while an unmasked status bit was set");
endmodule // amp_mode_and_fault_registers

/* verilog/amp_regs_pkg.sv */
package amp_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_OUTPUT_STAGE = 4'h6;
    localparam logic [3:0] IDX_RESERVED_SLOT = 4'h7;
    localparam logic [3:0] IDX_FAULT = 4'h8;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'ha;
    localparam logic [3:0] IDX_IRQ_MASK = 4'hb;
    localparam logic [3:0] IDX_SPEED = 4'hc;
    localparam int ADDR_W = 8;

    // output_stage_config fields
    localparam int TOPO_BIT = 7;
    localparam int RATE_MSB = 6;
    localparam int RATE_LSB = 4;
    localparam int GAIN_MSB = 3;
    localparam int GAIN_LSB = 2;
    localparam int CHSEL_BIT = 1;
    localparam int RSVD_BIT = 0;
    localparam logic [7:0] OUTPUT_STAGE_RESET = 8'h51;
    localparam logic [1:0] GAIN_RESERVED = 2'h3;

    // fault_config_and_status fields
    localparam int TRIP_MSB = 5;
    localparam int TRIP_LSB = 4;
    localparam logic [1:0] TRIP_RESET = 2'h0;
    localparam int CLKF_BIT = 3;
    localparam int OCF_BIT = 2;
    localparam int DCF_BIT = 1;
    localparam int OTF_BIT = 0;
    localparam int FLAG_W = 4;

    // speed control register, and the interrupt status and mask reset value
    localparam int DOUBLE_SPEED_BIT = 0;
    localparam logic DOUBLE_SPEED_RESET = 1'b0;
    localparam logic [FLAG_W-1:0] IRQ_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // switching rate as a multiple of the frame clock, per rate code
    localparam logic [4:0] RATE_MULT [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
    // overcurrent trip level in percent of nominal, per scale code
    localparam logic [6:0] TRIP_PCT [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
    localparam int SYNC_W = 5;
    // idle level of each synchronised pin, shutdown on top
    localparam logic [SYNC_W-1:0] PIN_IDLE = 5'h10;
endpackage

/* verilog/fault_if.sv */
`timescale 1ns/1ps
interface fault_if;
    logic clock_fault_flag;
    logic overcurrent_fault_flag;
    logic output_offset_fault_flag;
    logic overtemp_fault_flag;
    logic shutdown_released;
    modport monitor (
        output clock_fault_flag,
        output overcurrent_fault_flag,
        output output_offset_fault_flag,
        output overtemp_fault_flag,
        output shutdown_released
    );
    modport consumer (
        input clock_fault_flag,
        input overcurrent_fault_flag,
        input output_offset_fault_flag,
        input overtemp_fault_flag,
        input shutdown_released
    );
endinterface

/* verilog/fault_monitor.sv */
`timescale 1ns/1ps
module fault_monitor
    import amp_regs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_invalid,
    input wire logic overcurrent_detect,
    input wire logic output_offset_detect,
    input wire logic overtemp_detect,
    input wire logic amp_shutdown_n,
    fault_if.monitor flags
);
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
    logic shutdown_prev;
    logic toggle_done;

    assign raw = {amp_shutdown_n, clock_invalid, overcurrent_detect, output_offset_detect, overtemp_detect};

    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta[i] <= PIN_IDLE[i];
                    sync[i] <= PIN_IDLE[i];
                end else begin
                    meta[i] <= raw[i];
                    sync[i] <= meta[i];
                end
            end
        end
    endgenerate

    // shutdown pulled low and released again completes a toggle
    assign toggle_done = sync[4] & ~shutdown_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_prev <= PIN_IDLE[SYNC_W-1];
        end else begin
            shutdown_prev <= sync[4];
        end
    end

    // clock fault follows the detector with no memory
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags.clock_fault_flag <= 1'b0;
        end else begin
            flags.clock_fault_flag <= sync[3];
        end
    end

    // latched faults; a new fault wins over a toggle in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags.overcurrent_fault_flag <= 1'b0;
            flags.output_offset_fault_flag <= 1'b0;
            flags.overtemp_fault_flag <= 1'b0;
        end else begin
            flags.overcurrent_fault_flag <= sync[2] | (flags.overcurrent_fault_flag & ~toggle_done);
            flags.output_offset_fault_flag <= sync[1] | (flags.output_offset_fault_flag & ~toggle_done);
            flags.overtemp_fault_flag <= sync[0] | (flags.overtemp_fault_flag & ~toggle_done);
        end
    end

    assign flags.shutdown_released = sync[4];

    clock_recover_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync[3] |=> !flags.clock_fault_flag)
        else $error("clock fault flag stayed set after clocks became valid");

    fault_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags.overtemp_fault_flag && !toggle_done |=> flags.overtemp_fault_flag)
        else $error("over-temperature flag dropped without a shutdown toggle");
endmodule // fault_monitor
